// *** core/wdt_edge.sv ***
// Self-clearing rising edge detector
`default_nettype none
module wdt_edge (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic level,
  output logic rise
);
  logic last_reg;
  logic last_next;
  // Pulse for one cycle when level goes high
  always_comb begin
    last_next = level;
    rise = level & ~last_reg;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_reg <= 1'b0; // Matches the idle low level of the pin
    end else begin
      last_reg <= last_next;
    end
  end
endmodule
`default_nettype wire

// *** core/wdt_gpio_ctrl.sv ***
// Watchdog control, power-down delay and GPIO read-back over APB
`default_nettype none
module wdt_gpio_ctrl
  import wdt_pkg::*;
#(
  parameter int unsigned SEC_LEN = SEC_CYCLES,
  parameter int unsigned LED_HALF = LED_HALF_CYCLES,
  parameter int unsigned DELAY_TICK = DELAY_TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] gpio_group_one_pins,
  input wire logic [4:0] gpio_group_five_pins,
  input wire logic [7:0] gpio_group_six_pins,
  input wire logic kbc_reset_output,
  input wire logic power_button,
  output logic power_led,
  output logic soft_power_off,
  output logic power_down_req,
  output logic combined_gpio_irq_one,
  output logic combined_gpio_irq_two
);
  // Refuse timing values the dividers cannot serve
  if (SEC_LEN < 2 || LED_HALF < 1 || DELAY_TICK < 1) begin : g_bad_timing
    $error("Bad timing parameter");
  end

  typedef enum logic [2:0] {
    PD_IDLE = 3'b001,
    PD_COUNT = 3'b010,
    PD_STOPPED = 3'b100
  } pd_state_e;

  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] delay_reg;
  logic [7:0] delay_next;
  logic [7:0] value_reg;
  logic [7:0] value_next;
  logic [7:0] units_reg;
  logic [7:0] units_next;
  logic [7:0] irq_sel_reg;
  logic [7:0] irq_sel_next;
  logic cfg_mode_reg;
  logic cfg_mode_next;
  logic [7:0] elapsed_reg;
  logic [7:0] elapsed_next;
  logic [5:0] sec_reg;
  logic [5:0] sec_next;
  logic [7:0] pd_cnt_reg;
  logic [7:0] pd_cnt_next;
  pd_state_e pd_reg;
  pd_state_e pd_next;
  logic led_reg;
  logic led_next;
  logic soft_off_reg;
  logic soft_off_next;
  logic pdreq_reg;
  logic pdreq_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic slverr_reg;
  logic slverr_next;
  logic [7:0] grp1_reg;
  logic [7:0] grp5_reg;
  logic [7:0] grp6_reg;

  // Bus decode
  logic access;
  logic wr;
  logic rd;
  logic hit;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic wr_ctrl;
  logic [7:0] rd_val;
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd = psel & ~penable & ~pwrite; // Read setup, data ready for access
  assign idx = paddr[9:2];
  assign wbyte = pwdata[7:0];
  assign pready = 1'b1;
  assign prdata = rdata_reg;
  assign pslverr = slverr_reg;

  // Register index lookup, config space or runtime mirror
  always_comb begin
    hit = 1'b1;
    rd_val = 8'h00;
    wr_ctrl = 1'b0;
    if (paddr[11:10] != 2'b00 || paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end else if (idx == IDX_CFG_MODE) begin
      rd_val = {7'h0, cfg_mode_reg};
    end else if (cfg_mode_reg && idx == IDX_CTRL) begin
      rd_val = ctrl_reg;
      wr_ctrl = wr;
    end else if (cfg_mode_reg && idx == IDX_GRP1) begin
      rd_val = grp1_reg;
    end else if (cfg_mode_reg && idx == IDX_GRP5) begin
      rd_val = grp5_reg & GRP5_MASK;
    end else if (cfg_mode_reg && idx == IDX_GRP6) begin
      rd_val = grp6_reg;
    end else if (cfg_mode_reg && idx == IDX_DELAY) begin
      rd_val = delay_reg;
    end else if (cfg_mode_reg && idx == IDX_VALUE) begin
      rd_val = value_reg;
    end else if (cfg_mode_reg && idx == IDX_UNITS) begin
      rd_val = units_reg;
    end else if (cfg_mode_reg && idx == IDX_IRQ_SEL) begin
      rd_val = irq_sel_reg;
    end else if (cfg_mode_reg && idx == IDX_PWR_STAT) begin
      rd_val = {5'h0, pdreq_reg, soft_off_reg, pd_reg == PD_COUNT};
    end else if (!cfg_mode_reg && idx == RT_GRP1) begin
      rd_val = grp1_reg;
    end else if (!cfg_mode_reg && idx == RT_CTRL) begin
      rd_val = ctrl_reg;
      wr_ctrl = wr;
    end else if (!cfg_mode_reg && idx == RT_GRP5) begin
      rd_val = grp5_reg & GRP5_MASK;
    end else if (!cfg_mode_reg && idx == RT_GRP6) begin
      rd_val = grp6_reg;
    end else if (!cfg_mode_reg && idx == RT_PWR_STAT) begin
      rd_val = {5'h0, pdreq_reg, soft_off_reg, pd_reg == PD_COUNT};
    end else begin
      hit = 1'b0;
    end
  end

  // Dividers for seconds, LED half period and delay ticks
  logic sec_tick;
  logic led_tick;
  logic pd_tick;
  logic wd_run;
  logic pd_restart;
  // Restart also clears the delay tick phase, giving a full delay
  assign pd_restart = wr_ctrl & wbyte[CTRL_RESTART];
  assign wd_run = (value_reg != 8'h00) & ~ctrl_reg[CTRL_STATUS];
  wdt_tick #(.PERIOD(SEC_LEN)) u_sec (
    .pclk(pclk),
    .presetn(presetn),
    .run(wd_run),
    .tick(sec_tick)
  );
  wdt_tick #(.PERIOD(LED_HALF)) u_led (
    .pclk(pclk),
    .presetn(presetn),
    .run(ctrl_reg[CTRL_LED]),
    .tick(led_tick)
  );
  wdt_tick #(.PERIOD(DELAY_TICK)) u_pd (
    .pclk(pclk),
    .presetn(presetn),
    .run(pd_reg == PD_COUNT && !pd_restart),
    .tick(pd_tick)
  );

  // Keyboard reset edge and button edge
  logic kbc_rise;
  logic btn_rise;
  wdt_edge u_kbc (
    .pclk(pclk),
    .presetn(presetn),
    .level(kbc_reset_output),
    .rise(kbc_rise)
  );
  wdt_edge u_btn (
    .pclk(pclk),
    .presetn(presetn),
    .level(power_button),
    .rise(btn_rise)
  );

  // Timeout events and watchdog count
  logic force_ev;
  logic kbc_ev;
  logic count_ev;
  logic timeout_ev;
  logic unit_done;
  always_comb begin
    force_ev = wr_ctrl & wbyte[CTRL_FORCE];
    kbc_ev = kbc_rise & ctrl_reg[CTRL_KBC_EN];
    unit_done = 1'b0;
    sec_next = sec_reg;
    elapsed_next = elapsed_reg;
    if (!wd_run) begin
      sec_next = 6'h0;
      elapsed_next = 8'h0;
    end else if (sec_tick) begin
      if (!units_reg[UNITS_SEC] && sec_reg != 6'(SEC_PER_MIN - 1)) begin
        sec_next = sec_reg + 6'h1;
      end else begin
        sec_next = 6'h0;
        unit_done = 1'b1;
      end
    end
    if (unit_done) begin
      elapsed_next = elapsed_reg + 8'h1;
    end
    count_ev = unit_done & (elapsed_reg + 8'h1 == value_reg);
    timeout_ev = force_ev | kbc_ev | count_ev;
  end

  // Control register: stored bits, self-clearing strobes
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next[CTRL_STATUS] = wbyte[CTRL_STATUS];
      ctrl_next[CTRL_LED] = wbyte[CTRL_LED];
      ctrl_next[CTRL_KBC_EN] = wbyte[CTRL_KBC_EN];
    end
    if (timeout_ev) begin
      ctrl_next[CTRL_STATUS] = 1'b1;
    end
    ctrl_next[CTRL_FORCE] = 1'b0;
    ctrl_next[4] = 1'b0;
    ctrl_next[CTRL_STOP] = (pd_next == PD_STOPPED);
    ctrl_next[CTRL_RESTART] = 1'b0;
    ctrl_next[CTRL_SOFT_OFF] = 1'b0;
  end

  // Power-down delay sequence
  always_comb begin
    pd_next = pd_reg;
    pd_cnt_next = pd_cnt_reg;
    pdreq_next = 1'b0;
    soft_off_next = wr_ctrl & wbyte[CTRL_SOFT_OFF];
    case (pd_reg)
      PD_IDLE: begin
        if (btn_rise) begin
          pd_next = PD_COUNT;
          pd_cnt_next = 8'h0;
        end
      end
      PD_COUNT: begin
        if (pd_tick) begin
          pd_cnt_next = pd_cnt_reg + 8'h1;
        end
        if (pd_tick && pd_cnt_reg + 8'h1 >= delay_reg) begin
          pd_next = PD_IDLE;
          pdreq_next = 1'b1;
        end
      end
      PD_STOPPED: begin
        if (btn_rise) begin
          pd_next = PD_COUNT;
          pd_cnt_next = 8'h0;
        end
      end
      default: pd_next = PD_IDLE;
    endcase
    if (wr_ctrl && wbyte[CTRL_RESTART]) begin
      pd_next = PD_COUNT;
      pd_cnt_next = 8'h0;
      pdreq_next = 1'b0;
    end else if (wr_ctrl && wbyte[CTRL_STOP] && pd_reg == PD_COUNT) begin
      pd_next = PD_STOPPED;
      pdreq_next = 1'b0;
    end
  end

  // Remaining configuration, LED and bus answer
  always_comb begin
    delay_next = delay_reg;
    value_next = value_reg;
    units_next = units_reg;
    irq_sel_next = irq_sel_reg;
    cfg_mode_next = cfg_mode_reg;
    if (wr && hit && idx == IDX_CFG_MODE) begin
      cfg_mode_next = wbyte[0];
    end
    if (wr && hit && cfg_mode_reg && idx == IDX_DELAY) begin
      delay_next = wbyte;
    end
    if (wr && hit && cfg_mode_reg && idx == IDX_VALUE) begin
      value_next = wbyte;
    end
    if (wr && hit && cfg_mode_reg && idx == IDX_UNITS) begin
      units_next = {wbyte[UNITS_SEC], 7'h0};
    end
    if (wr && hit && cfg_mode_reg && idx == IDX_IRQ_SEL) begin
      irq_sel_next = {6'h0, wbyte[1:0]};
    end
    led_next = ctrl_reg[CTRL_LED] ? (led_reg ^ led_tick) : 1'b0;
    // Captured in setup so data and error stand through the access cycle
    rdata_next = rd ? {24'h0, rd_val} : rdata_reg;
    slverr_next = psel & ~penable & ~hit;
  end

  // Group interrupt outputs, LED and power pin outputs
  assign combined_gpio_irq_one = irq_sel_reg[0] & (|grp1_reg);
  assign combined_gpio_irq_two = irq_sel_reg[1] & ((|grp5_reg[4:0]) | (|grp6_reg));
  assign power_led = led_reg;
  assign soft_power_off = soft_off_reg;
  assign power_down_req = pdreq_reg;

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
      delay_reg <= DELAY_RESET;
      value_reg <= VALUE_RESET;
      units_reg <= UNITS_RESET;
      irq_sel_reg <= 8'h00;
      cfg_mode_reg <= 1'b0;
      elapsed_reg <= 8'h00;
      sec_reg <= 6'h0;
      pd_cnt_reg <= 8'h00;
      pd_reg <= PD_IDLE;
      led_reg <= 1'b0;
      soft_off_reg <= 1'b0;
      pdreq_reg <= 1'b0;
      rdata_reg <= 32'h0;
      slverr_reg <= 1'b0;
      grp1_reg <= 8'h00;
      grp5_reg <= 8'h00;
      grp6_reg <= 8'h00;
    end else begin
      ctrl_reg <= ctrl_next;
      delay_reg <= delay_next;
      value_reg <= value_next;
      units_reg <= units_next;
      irq_sel_reg <= irq_sel_next;
      cfg_mode_reg <= cfg_mode_next;
      elapsed_reg <= elapsed_next;
      sec_reg <= sec_next;
      pd_cnt_reg <= pd_cnt_next;
      pd_reg <= pd_next;
      led_reg <= led_next;
      soft_off_reg <= soft_off_next;
      pdreq_reg <= pdreq_next;
      rdata_reg <= rdata_next;
      slverr_reg <= slverr_next;
      grp1_reg <= gpio_group_one_pins;
      grp5_reg <= {3'h0, gpio_group_five_pins};
      grp6_reg <= gpio_group_six_pins;
    end
  end
endmodule
`default_nettype wire

// *** core/wdt_pkg.sv ***
// Constants for the watchdog control and GPIO read-back block
`default_nettype none
package wdt_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned LED_HALF_MS = 500;
  localparam int unsigned LED_HALF_CYCLES = CLK_HZ / 1000 * LED_HALF_MS;
  localparam int unsigned SEC_CYCLES = CLK_HZ;
  localparam int unsigned DELAY_TICK_MS = 100;
  localparam int unsigned DELAY_TICK_CYCLES = CLK_HZ / 1000 * DELAY_TICK_MS;
  localparam int unsigned SEC_PER_MIN = 60;
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_DELAY = 8'hb8;
  localparam logic [7:0] IDX_UNITS = 8'hf1;
  localparam logic [7:0] IDX_VALUE = 8'hf2;
  localparam logic [7:0] IDX_CTRL = 8'hf4;
  localparam logic [7:0] IDX_GRP1 = 8'hf6;
  localparam logic [7:0] IDX_GRP5 = 8'hf9;
  localparam logic [7:0] IDX_GRP6 = 8'hfa;
  localparam logic [7:0] IDX_IRQ_SEL = 8'hfc;
  localparam logic [7:0] IDX_CFG_MODE = 8'hfd;
  localparam logic [7:0] IDX_PWR_STAT = 8'hfe;
  localparam logic [7:0] RT_GRP1 = 8'h01;
  localparam logic [7:0] RT_CTRL = 8'h02;
  localparam logic [7:0] RT_GRP5 = 8'h03;
  localparam logic [7:0] RT_GRP6 = 8'h04;
  localparam logic [7:0] RT_PWR_STAT = 8'h05;
  // Control and units fields
  localparam int CTRL_STATUS = 0;
  localparam int CTRL_LED = 1;
  localparam int CTRL_FORCE = 2;
  localparam int CTRL_KBC_EN = 3;
  localparam int CTRL_STOP = 5;
  localparam int CTRL_RESTART = 6;
  localparam int CTRL_SOFT_OFF = 7;
  localparam int UNITS_SEC = 7;
  // Reset values and the group five read mask
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DELAY_RESET = 8'h05;
  localparam logic [7:0] VALUE_RESET = 8'h00;
  localparam logic [7:0] UNITS_RESET = 8'h00;
  localparam logic [7:0] GRP5_MASK = 8'h1f;
endpackage
`default_nettype wire

// *** core/wdt_tick.sv ***
// Divider that pulses once every PERIOD cycles while running
`default_nettype none
module wdt_tick #(
  parameter int unsigned PERIOD = 20000000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  output logic tick
);
  // Refuse a divider that can never pulse
  if (PERIOD < 1) begin : g_bad_period
    $error("PERIOD must be at least one");
  end
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  // Count up, wrap and pulse at the end
  always_comb begin
    cnt_next = cnt_reg;
    tick = 1'b0;
    if (!run) begin
      cnt_next = 32'h0;
    end else if (cnt_reg == 32'(PERIOD - 1)) begin
      cnt_next = 32'h0;
      tick = 1'b1;
    end else begin
      cnt_next = cnt_reg + 32'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 32'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule
`default_nettype wire

// *** test/kbc_model.sv ***
// Keyboard controller reset output model
`default_nettype none
module kbc_model #(
  parameter int HOLD = 24
) (
  input wire logic pclk,
  input wire logic go,
  output logic kbc_reset_output
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  // High for over 1 us per request, then low
  always @(posedge pclk) begin
    if (go) begin
      n <= HOLD;
    end else if (n > 0) begin
      n <= n - 1;
    end
  end
  assign kbc_reset_output = (n > 0);
endmodule
`default_nettype wire

// *** test/tb.sv ***
// Bench for the watchdog control and GPIO read-back block
`default_nettype none
module tb
  import wdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, power_button = 1'b0, kgo = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, power_led, soft_power_off, power_down_req, kbc_reset_output;
  logic combined_gpio_irq_one, combined_gpio_irq_two, er;
  logic [7:0] gpio_group_one_pins = 8'h00, gpio_group_six_pins = 8'h00, rd;
  logic [4:0] gpio_group_five_pins = 5'h00;
  int fail_count = 0, checks_done = 0, spo = 0, pdq = 0, b, n;
  // 20 MHz clock
  always #25 pclk = ~pclk;
  wdt_gpio_ctrl #(.SEC_LEN(20), .LED_HALF(10), .DELAY_TICK(10)) u_dut (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .gpio_group_one_pins, .gpio_group_five_pins, .gpio_group_six_pins, .kbc_reset_output,
    .power_button, .power_led, .soft_power_off, .power_down_req, .combined_gpio_irq_one,
    .combined_gpio_irq_two);
  kbc_model u_kbc (.pclk, .go(kgo), .kbc_reset_output);
  // Pulse counters
  always @(posedge pclk) begin
    if (soft_power_off === 1'b1) spo <= spo + 1;
    if (power_down_req === 1'b1) pdq <= pdq + 1;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic give_up(input string nm);
    chk(nm, 8'h01, 8'h00);
    print_verdict();
  endtask
  // APB transfer, read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) give_up("pready");
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~paddr;
    pwdata <= ~pwdata;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [7:0] i, input logic [7:0] e);
    apb(1'b0, i, 8'h00);
    chk($sformatf("reg %h", i), e, rd);
  endtask
  task automatic wled(input logic v);
    n = 0;
    while (power_led !== v && n < 100) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 100) give_up("led wait");
  endtask
  task automatic pulse(input bit btn);
    if (btn) begin
      power_button <= 1'b1;
    end else begin
      kgo <= 1'b1;
    end
    @(posedge pclk);
    power_button <= 1'b0;
    kgo <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge pclk);
  endtask
  // Hang guard
  initial begin
    idle(30000);
    give_up("timeout");
  end
  // Main sequence
  initial begin
    idle(8);
    presetn <= 1'b1;
    idle(1);
    rdc(RT_CTRL, 8'h00);
    gpio_group_one_pins <= 8'ha5;
    gpio_group_five_pins <= 5'h1b;
    gpio_group_six_pins <= 8'h3c;
    idle(2);
    rdc(RT_GRP1, 8'ha5);
    rdc(RT_GRP5, 8'h1b);
    rdc(RT_GRP6, 8'h3c);
    chk("no slverr", 8'h00, {7'h00, er});
    rdc(IDX_GRP1, 8'h00);
    apb(1'b1, IDX_CFG_MODE, 8'h01);
    rdc(IDX_GRP1, 8'ha5);
    rdc(IDX_GRP5, 8'h1b);
    rdc(IDX_GRP6, 8'h3c);
    rdc(8'h33, 8'h00);
    chk("slverr", 8'h01, {7'h00, er});
    apb(1'b1, IDX_IRQ_SEL, 8'h03);
    chk("irq", 8'h03, {6'h00, combined_gpio_irq_one, combined_gpio_irq_two});
    $display("test gpio done");
    apb(1'b1, IDX_CTRL, 8'h04);
    rdc(IDX_CTRL, 8'h01);
    apb(1'b1, IDX_CTRL, 8'h00);
    rdc(IDX_CTRL, 8'h00);
    pulse(1'b0);
    idle(30);
    rdc(IDX_CTRL, 8'h00);
    apb(1'b1, IDX_CTRL, 8'h08);
    pulse(1'b0);
    idle(30);
    rdc(IDX_CTRL, 8'h09);
    apb(1'b1, IDX_CTRL, 8'h00);
    apb(1'b1, IDX_UNITS, 8'h80);
    apb(1'b1, IDX_VALUE, 8'h02);
    idle(25);
    rdc(IDX_CTRL, 8'h00);
    idle(15);
    rdc(IDX_CTRL, 8'h01);
    apb(1'b1, IDX_VALUE, 8'h00);
    apb(1'b1, IDX_CTRL, 8'h00);
    idle(60);
    rdc(IDX_CTRL, 8'h00);
    apb(1'b1, IDX_UNITS, 8'h00);
    apb(1'b1, IDX_VALUE, 8'h01);
    idle(1150);
    rdc(IDX_CTRL, 8'h00);
    idle(100);
    rdc(IDX_CTRL, 8'h01);
    apb(1'b1, IDX_VALUE, 8'h00);
    $display("test watchdog done");
    apb(1'b1, IDX_CTRL, 8'h02);
    wled(1'b1);
    wled(1'b0);
    chk("led high", 8'd10, n[7:0]);
    wled(1'b1);
    chk("led low", 8'd10, n[7:0]);
    apb(1'b1, IDX_CTRL, 8'h80);
    idle(2);
    chk("soft off", 8'd1, spo[7:0]);
    chk("led off", 8'h00, {7'h00, power_led});
    b = pdq;
    pulse(1'b1);
    idle(33);
    chk("pd early", 8'd0, 8'(pdq - b));
    idle(25);
    chk("pd 500ms", 8'd1, 8'(pdq - b));
    apb(1'b1, IDX_DELAY, 8'h04);
    pulse(1'b1);
    idle(28);
    chk("pd short", 8'd1, 8'(pdq - b));
    idle(15);
    chk("pd 4 ticks", 8'd2, 8'(pdq - b));
    pulse(1'b1);
    idle(20);
    apb(1'b1, IDX_CTRL, 8'h40);
    idle(38);
    chk("pd rearm", 8'd2, 8'(pdq - b));
    idle(7);
    chk("pd rearm end", 8'd3, 8'(pdq - b));
    pulse(1'b1);
    idle(5);
    rdc(IDX_CTRL, 8'h00);
    apb(1'b1, IDX_CTRL, 8'h20);
    rdc(IDX_CTRL, 8'h20);
    idle(50);
    chk("pd stopped", 8'd3, 8'(pdq - b));
    $display("test power done");
    print_verdict();
  end
endmodule
`default_nettype wire

// *** test/wdt_gpio_ctrl_asserts.sv ***
// Port checker for the watchdog control block
`default_nettype none
module wdt_gpio_ctrl_asserts
  import wdt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic [7:0] gpio_group_one_pins,
  input wire logic [4:0] gpio_group_five_pins,
  input wire logic [7:0] gpio_group_six_pins,
  input wire logic soft_power_off,
  input wire logic power_down_req,
  input wire logic combined_gpio_irq_one,
  input wire logic combined_gpio_irq_two
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_ctrl;
  // Read of the control register at either index
  assign rd_ctrl = psel && penable && !pwrite &&
    (paddr == {2'b00, IDX_CTRL, 2'b00} || paddr == {2'b00, RT_CTRL, 2'b00});
  chk_pready_tied: assert property (pready)
    else $error("pready low");
  chk_rdata_upper: assert property (prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  chk_ctrl_selfclr: assert property (rd_ctrl |-> prdata[7:6] == 2'b00 && !prdata[2])
    else $error("self clearing bit reads 1");
  chk_soft_off_cause: assert property ($rose(soft_power_off) |->
    $past(psel && penable && pwrite && pwdata[7]))
    else $error("soft power off without write");
  chk_soft_off_once: assert property (soft_power_off |=> !soft_power_off)
    else $error("soft power off too long");
  chk_pdreq_one: assert property (power_down_req |=> !power_down_req)
    else $error("power down request too long");
  chk_irq_one: assert property (combined_gpio_irq_one |-> $past(|gpio_group_one_pins))
    else $error("irq one without pin");
  chk_irq_two: assert property (combined_gpio_irq_two |->
    $past(|{gpio_group_five_pins, gpio_group_six_pins}))
    else $error("irq two without pin");
endmodule
bind wdt_gpio_ctrl wdt_gpio_ctrl_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .gpio_group_one_pins, .gpio_group_five_pins,
  .gpio_group_six_pins, .soft_power_off, .power_down_req, .combined_gpio_irq_one,
  .combined_gpio_irq_two);
`default_nettype wire
